//--- lsd_pkg.sv
package lsd_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  // register indices
  localparam logic [3:0] REG_CENTER_H = 4'h0;
  localparam logic [3:0] REG_CENTER_V = 4'h1;
  localparam logic [3:0] REG_HCOEFF = 4'h2;
  localparam logic [3:0] REG_VCOEFF = 4'h3;
  localparam logic [3:0] REG_GAIN_CTL = 4'h4;
  localparam logic [3:0] REG_GAIN_WDATA = 4'h5;
  localparam logic [3:0] REG_GAIN_RDATA = 4'h6;
  localparam logic [3:0] REG_DEF_CTL = 4'h7;
  localparam logic [3:0] REG_SAT_LEVEL = 4'h8;
  localparam logic [3:0] REG_DEF_MEM_CTL = 4'h9;
  localparam logic [3:0] REG_LSC_CFG = 4'hA;
  localparam logic [3:0] REG_ENTRY_VPOS = 4'hB;
  localparam logic [3:0] REG_ENTRY_HPOS = 4'hC;
  localparam logic [3:0] REG_ENTRY_LINE = 4'hD;
  localparam logic [3:0] REG_ENTRY_UPPER = 4'hE;
  localparam logic [3:0] REG_ENTRY_LOWER = 4'hF;
  // field positions
  localparam int CHSEL_LSB = 14;
  localparam int POS_W = 14;
  localparam int COEF_W = 8;
  localparam int GCTL_BUSY = 4;
  localparam int GCTL_RDSEL = 3;
  localparam int GCTL_ARST = 2;
  localparam int DCTL_SHIFT_LSB = 8;
  localparam int DCTL_UPDIS = 7;
  localparam int DCTL_MODE_LSB = 5;
  localparam int DCTL_VEN = 4;
  localparam int DCTL_GEN = 0;
  localparam int DMC_CLR = 4;
  localparam int DMC_ARST = 2;
  localparam int DMC_RD = 1;
  localparam int DMC_WR = 0;
  localparam int FMT_LSB = 4;
  localparam int EPOS_W = 12;
  localparam int ELVL_W = 8;
  localparam int ENTRY_W = 2 * EPOS_W + 3 * ELVL_W;
  // encodings and reset values
  localparam logic [1:0] CHAN_RESERVED = 2'h3;
  localparam logic [2:0] SHIFT_MAX = 3'h6;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  typedef enum logic [1:0] {
    GS_IDLE = 2'b01,
    GS_ACCESS = 2'b10
  } lsd_gain_state_t;
  typedef enum logic [2:0] {
    DS_IDLE = 3'b001,
    DS_CLEAR = 3'b010,
    DS_XFER = 3'b100
  } lsd_def_state_t;
endpackage

//--- lsd_regs.sv
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ps
module lsd_regs #(
  parameter int GAIN_DEPTH = 256,
  parameter int DEFECT_DEPTH = 16
) (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic [lsd_pkg::ADDR_W-1:0] addr_in,
  input wire logic [lsd_pkg::DATA_W-1:0] wdata_in,
  input wire logic write_in,
  input wire logic read_in,
  input wire logic vertical_sync_in,
  output logic [lsd_pkg::DATA_W-1:0] rdata_out,
  output logic vline_corr_enable_out,
  output logic general_defect_enable_out,
  output logic [2:0] vline_level_shift_out,
  output logic vline_upper_disable_out,
  output logic [1:0] vline_corr_mode_out,
  output logic [lsd_pkg::POS_W-1:0] vline_sat_level_out,
  output logic [1:0] gain_factor_format_out
);
  localparam int GA_W = $clog2(GAIN_DEPTH);
  localparam int DA_W = $clog2(DEFECT_DEPTH);

  if (GAIN_DEPTH < 2 || (GAIN_DEPTH & (GAIN_DEPTH - 1)) != 0)
  begin
    $error("GAIN_DEPTH must be a power of two, at least 2");
  end
  if (DEFECT_DEPTH < 2 || (DEFECT_DEPTH & (DEFECT_DEPTH - 1)) != 0)
  begin
    $error("DEFECT_DEPTH must be a power of two, at least 2");
  end

  // reset release through two flops
  logic [1:0] rst_sync_ff;
  logic rst_n;
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
      rst_sync_ff <= 2'b00;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_n = rst_sync_ff[1];

  // vertical sync: three flops, level moves only when the last two agree
  logic [2:0] vs_sync_ff;
  logic vs_level_ff;
  logic vs_rise;
  always_ff @(posedge clock_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vs_sync_ff <= 3'b000;
      vs_level_ff <= 1'b0;
    end
    else
    begin
      vs_sync_ff <= {vs_sync_ff[1:0], vertical_sync_in};
      if (vs_sync_ff[1] == vs_sync_ff[2])
        vs_level_ff <= vs_sync_ff[2];
    end
  end
  assign vs_rise = (vs_sync_ff[1] == vs_sync_ff[2]) && vs_sync_ff[2] && !vs_level_ff;

  // decode
  wire wr_ch = write_in && addr_in == lsd_pkg::REG_CENTER_H;
  wire wr_cv = write_in && addr_in == lsd_pkg::REG_CENTER_V;
  wire wr_kh = write_in && addr_in == lsd_pkg::REG_HCOEFF;
  wire wr_kv = write_in && addr_in == lsd_pkg::REG_VCOEFF;
  wire wr_gctl = write_in && addr_in == lsd_pkg::REG_GAIN_CTL;
  wire wr_gdat = write_in && addr_in == lsd_pkg::REG_GAIN_WDATA;
  wire wr_dctl = write_in && addr_in == lsd_pkg::REG_DEF_CTL;
  wire wr_sat = write_in && addr_in == lsd_pkg::REG_SAT_LEVEL;
  wire wr_dmc = write_in && addr_in == lsd_pkg::REG_DEF_MEM_CTL;
  wire wr_cfg = write_in && addr_in == lsd_pkg::REG_LSC_CFG;

  // per-channel shading parameters
  logic [1:0] chan_sel_ff;
  logic [lsd_pkg::POS_W-1:0] center_h_ff [3];
  logic [lsd_pkg::POS_W-1:0] center_v_ff [3];
  logic [2*lsd_pkg::COEF_W-1:0] hcoeff_ff [3];
  logic [2*lsd_pkg::COEF_W-1:0] vcoeff_ff [3];
  wire [1:0] new_chan = wdata_in[lsd_pkg::CHSEL_LSB +: 2];
  wire chan_ok = chan_sel_ff != lsd_pkg::CHAN_RESERVED;
  always_ff @(posedge clock_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chan_sel_ff <= 2'b00;
      for (int i = 0; i < 3; i++)
      begin
        center_h_ff[i] <= '0;
        center_v_ff[i] <= '0;
        hcoeff_ff[i] <= '0;
        vcoeff_ff[i] <= '0;
      end
    end
    else
    begin
      if (wr_ch)
        chan_sel_ff <= new_chan;
      if (wr_ch && new_chan != lsd_pkg::CHAN_RESERVED)
        center_h_ff[new_chan] <= wdata_in[lsd_pkg::POS_W-1:0];
      if (wr_cv && chan_ok)
        center_v_ff[chan_sel_ff] <= wdata_in[lsd_pkg::POS_W-1:0];
      if (wr_kh && chan_ok)
        hcoeff_ff[chan_sel_ff] <= wdata_in;
      if (wr_kv && chan_ok)
        vcoeff_ff[chan_sel_ff] <= wdata_in;
    end
  end

  // gain tables; each word is one half-word location, packed per format
  logic [lsd_pkg::DATA_W-1:0] gain_mem [3][GAIN_DEPTH];
  lsd_pkg::lsd_gain_state_t gstate_ff;
  logic gain_rdsel_ff;
  logic gain_arst_ff;
  logic [1:0] gain_tsel_ff;
  logic [lsd_pkg::DATA_W-1:0] gain_wdata_ff;
  logic [lsd_pkg::DATA_W-1:0] gain_rdata_ff;
  logic [GA_W-1:0] gain_ptr_ff;
  logic [GA_W-1:0] gain_addr_ff;
  logic [1:0] gain_fmt_ff;
  wire gain_busy = gstate_ff == lsd_pkg::GS_ACCESS;
  // writes during busy are dropped: the access in flight owns the pointer
  wire gain_start = wr_gdat && !gain_busy;
  wire gain_tbl_ok = gain_tsel_ff != lsd_pkg::CHAN_RESERVED;
  always_ff @(posedge clock_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gstate_ff <= lsd_pkg::GS_IDLE;
      gain_rdsel_ff <= 1'b0;
      gain_arst_ff <= 1'b0;
      gain_tsel_ff <= 2'b00;
      gain_wdata_ff <= lsd_pkg::RESET_WORD;
      gain_rdata_ff <= lsd_pkg::RESET_WORD;
      gain_ptr_ff <= '0;
      gain_addr_ff <= '0;
      gain_fmt_ff <= 2'b00;
    end
    else
    begin
      if (wr_cfg)
        gain_fmt_ff <= wdata_in[lsd_pkg::FMT_LSB +: 2];
      if (wr_gctl)
      begin
        gain_rdsel_ff <= wdata_in[lsd_pkg::GCTL_RDSEL];
        gain_arst_ff <= wdata_in[lsd_pkg::GCTL_ARST];
        gain_tsel_ff <= wdata_in[1:0];
      end
      case (gstate_ff)
        lsd_pkg::GS_IDLE:
        begin
          if (gain_start)
          begin
            gain_wdata_ff <= wdata_in;
            gain_addr_ff <= gain_arst_ff ? '0 : gain_ptr_ff;
            gain_arst_ff <= 1'b0;
            gstate_ff <= lsd_pkg::GS_ACCESS;
          end
        end
        lsd_pkg::GS_ACCESS:
        begin
          if (gain_rdsel_ff && gain_tbl_ok)
            gain_rdata_ff <= gain_mem[gain_tsel_ff][gain_addr_ff];
          gain_ptr_ff <= GA_W'(gain_addr_ff + 1);
          gstate_ff <= lsd_pkg::GS_IDLE;
        end
        default:
          gstate_ff <= lsd_pkg::GS_IDLE;
      endcase
    end
  end
  // one word holds factor 2N+1 high and 2N low in 8-bit format
  always_ff @(posedge clock_in)
  begin
    if (gain_busy && !gain_rdsel_ff && gain_tbl_ok)
      gain_mem[gain_tsel_ff][gain_addr_ff] <= gain_wdata_ff;
  end

  // defect correction controls and shadows
  logic [10:0] dctl_ff;
  logic [2:0] shift_ff;
  logic [lsd_pkg::POS_W-1:0] sat_ff;
  wire [2:0] wr_shift = wdata_in[lsd_pkg::DCTL_SHIFT_LSB +: 3];
  always_ff @(posedge clock_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dctl_ff <= '0;
      shift_ff <= '0;
      sat_ff <= '0;
      vline_corr_enable_out <= 1'b0;
      general_defect_enable_out <= 1'b0;
    end
    else
    begin
      if (wr_dctl)
      begin
        dctl_ff <= wdata_in[10:0];
        // a stray 7 is held at 6 so the shifted level never overflows 14 bits
        shift_ff <= (wr_shift > lsd_pkg::SHIFT_MAX) ? lsd_pkg::SHIFT_MAX : wr_shift;
      end
      if (wr_sat)
        sat_ff <= wdata_in[lsd_pkg::POS_W-1:0];
      if (vs_rise)
      begin
        vline_corr_enable_out <= dctl_ff[lsd_pkg::DCTL_VEN];
        general_defect_enable_out <= dctl_ff[lsd_pkg::DCTL_GEN];
      end
    end
  end
  assign vline_level_shift_out = shift_ff;
  assign vline_upper_disable_out = dctl_ff[lsd_pkg::DCTL_UPDIS];
  assign vline_corr_mode_out = dctl_ff[lsd_pkg::DCTL_MODE_LSB +: 2];
  assign vline_sat_level_out = sat_ff;
  assign gain_factor_format_out = gain_fmt_ff;

  // defect memory
  logic [lsd_pkg::ENTRY_W-1:0] def_mem [DEFECT_DEPTH];
  lsd_pkg::lsd_def_state_t dstate_ff;
  logic dm_clr_ff, dm_arst_ff, dm_rd_ff, dm_wr_ff;
  logic [DA_W-1:0] dm_ptr_ff;
  logic [DA_W-1:0] dm_addr_ff;
  logic [lsd_pkg::EPOS_W-1:0] ent_v_ff, ent_h_ff;
  logic [lsd_pkg::ELVL_W-1:0] ent_line_ff, ent_up_ff, ent_low_ff;
  wire dm_idle = dstate_ff == lsd_pkg::DS_IDLE;
  wire dm_go_clr = wr_dmc && dm_idle && wdata_in[lsd_pkg::DMC_CLR];
  wire dm_go_xfer = wr_dmc && dm_idle && !wdata_in[lsd_pkg::DMC_CLR]
                    && (wdata_in[lsd_pkg::DMC_RD] || wdata_in[lsd_pkg::DMC_WR]);
  wire dm_clr_last = dm_addr_ff == DA_W'(DEFECT_DEPTH - 1);
  wire [lsd_pkg::ENTRY_W-1:0] dm_entry = {ent_v_ff, ent_h_ff, ent_line_ff, ent_up_ff,
                                          ent_low_ff};
  wire [lsd_pkg::ENTRY_W-1:0] dm_q = def_mem[dm_addr_ff];
  always_ff @(posedge clock_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dstate_ff <= lsd_pkg::DS_IDLE;
      {dm_clr_ff, dm_arst_ff, dm_rd_ff, dm_wr_ff} <= 4'h0;
      dm_ptr_ff <= '0;
      dm_addr_ff <= '0;
    end
    else
    begin
      case (dstate_ff)
        lsd_pkg::DS_IDLE:
        begin
          if (wr_dmc)
          begin
            dm_clr_ff <= wdata_in[lsd_pkg::DMC_CLR];
            dm_arst_ff <= wdata_in[lsd_pkg::DMC_ARST];
            dm_rd_ff <= wdata_in[lsd_pkg::DMC_RD];
            dm_wr_ff <= wdata_in[lsd_pkg::DMC_WR];
          end
          if (dm_go_clr)
          begin
            dm_addr_ff <= '0;
            dstate_ff <= lsd_pkg::DS_CLEAR;
          end
          else if (dm_go_xfer)
          begin
            dm_addr_ff <= wdata_in[lsd_pkg::DMC_ARST] ? '0 : dm_ptr_ff;
            dstate_ff <= lsd_pkg::DS_XFER;
          end
        end
        lsd_pkg::DS_CLEAR:
        begin
          dm_addr_ff <= DA_W'(dm_addr_ff + 1);
          if (dm_clr_last)
          begin
            dm_clr_ff <= 1'b0;
            // clear wins: a read or write written with it must not stay pending
            dm_rd_ff <= 1'b0;
            dm_wr_ff <= 1'b0;
            dstate_ff <= lsd_pkg::DS_IDLE;
          end
        end
        lsd_pkg::DS_XFER:
        begin
          dm_ptr_ff <= DA_W'(dm_addr_ff + 1);
          dm_arst_ff <= 1'b0;
          dm_rd_ff <= 1'b0;
          dm_wr_ff <= 1'b0;
          dstate_ff <= lsd_pkg::DS_IDLE;
        end
        default:
          dstate_ff <= lsd_pkg::DS_IDLE;
      endcase
    end
  end
  always_ff @(posedge clock_in)
  begin
    if (dstate_ff == lsd_pkg::DS_CLEAR)
      def_mem[dm_addr_ff] <= '0;
    else if (dstate_ff == lsd_pkg::DS_XFER && dm_wr_ff)
      def_mem[dm_addr_ff] <= dm_entry;
  end
  // a finishing read beats a software write to the data registers
  wire dm_load = dstate_ff == lsd_pkg::DS_XFER && dm_rd_ff && !dm_wr_ff;
  always_ff @(posedge clock_in or negedge rst_n)
  begin
    if (!rst_n)
      {ent_v_ff, ent_h_ff, ent_line_ff, ent_up_ff, ent_low_ff} <= '0;
    else if (dm_load)
      {ent_v_ff, ent_h_ff, ent_line_ff, ent_up_ff, ent_low_ff} <= dm_q;
    else if (write_in)
    begin
      if (addr_in == lsd_pkg::REG_ENTRY_VPOS)
        ent_v_ff <= wdata_in[lsd_pkg::EPOS_W-1:0];
      if (addr_in == lsd_pkg::REG_ENTRY_HPOS)
        ent_h_ff <= wdata_in[lsd_pkg::EPOS_W-1:0];
      if (addr_in == lsd_pkg::REG_ENTRY_LINE)
        ent_line_ff <= wdata_in[lsd_pkg::ELVL_W-1:0];
      if (addr_in == lsd_pkg::REG_ENTRY_UPPER)
        ent_up_ff <= wdata_in[lsd_pkg::ELVL_W-1:0];
      if (addr_in == lsd_pkg::REG_ENTRY_LOWER)
        ent_low_ff <= wdata_in[lsd_pkg::ELVL_W-1:0];
    end
  end

  // read mux; reserved bits and reserved channel read zero
  logic [lsd_pkg::DATA_W-1:0] rd_mux;
  always_comb
  begin
    rd_mux = lsd_pkg::RESET_WORD;
    case (addr_in)
      lsd_pkg::REG_CENTER_H:
        rd_mux = {chan_sel_ff, chan_ok ? center_h_ff[chan_sel_ff] : 14'h0000};
      lsd_pkg::REG_CENTER_V:
        rd_mux = {2'b00, chan_ok ? center_v_ff[chan_sel_ff] : 14'h0000};
      lsd_pkg::REG_HCOEFF:
        rd_mux = chan_ok ? hcoeff_ff[chan_sel_ff] : lsd_pkg::RESET_WORD;
      lsd_pkg::REG_VCOEFF:
        rd_mux = chan_ok ? vcoeff_ff[chan_sel_ff] : lsd_pkg::RESET_WORD;
      lsd_pkg::REG_GAIN_CTL:
        rd_mux = {11'h000, gain_busy, gain_rdsel_ff, gain_arst_ff, gain_tsel_ff};
      lsd_pkg::REG_GAIN_WDATA:
        rd_mux = gain_wdata_ff;
      lsd_pkg::REG_GAIN_RDATA:
        rd_mux = gain_rdata_ff;
      lsd_pkg::REG_DEF_CTL:
        rd_mux = {5'h00, dctl_ff[10:4], 3'h0, dctl_ff[0]};
      lsd_pkg::REG_SAT_LEVEL:
        rd_mux = {2'b00, sat_ff};
      lsd_pkg::REG_DEF_MEM_CTL:
        rd_mux = {11'h000, dm_clr_ff, 1'b0, dm_arst_ff, dm_rd_ff, dm_wr_ff};
      lsd_pkg::REG_LSC_CFG:
        rd_mux = {10'h000, gain_fmt_ff, 4'h0};
      lsd_pkg::REG_ENTRY_VPOS:
        rd_mux = {4'h0, ent_v_ff};
      lsd_pkg::REG_ENTRY_HPOS:
        rd_mux = {4'h0, ent_h_ff};
      lsd_pkg::REG_ENTRY_LINE:
        rd_mux = {8'h00, ent_line_ff};
      lsd_pkg::REG_ENTRY_UPPER:
        rd_mux = {8'h00, ent_up_ff};
      lsd_pkg::REG_ENTRY_LOWER:
        rd_mux = {8'h00, ent_low_ff};
      default:
        rd_mux = lsd_pkg::RESET_WORD;
    endcase
  end
  always_ff @(posedge clock_in or negedge rst_n)
  begin
    if (!rst_n)
      rdata_out <= lsd_pkg::RESET_WORD;
    else if (read_in)
      rdata_out <= rd_mux;
  end

  // checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n);

  sequence s_gain_access;
    gain_busy ##1 !gain_busy;
  endsequence
  a_gain_busy_window: assert property (gain_start |=> s_gain_access)
    else $error("gain busy not a single access cycle");
  a_gain_arst_clear: assert property (gain_start |=> !gain_arst_ff)
    else $error("gain address reset not cleared by data write");
  a_gain_addr_zero: assert property (gain_start && gain_arst_ff |=> gain_addr_ff == '0)
    else $error("gain access did not start at offset zero");
  a_gain_ptr_step: assert property (gain_busy |=> gain_ptr_ff == GA_W'($past(gain_addr_ff) + 1))
    else $error("gain pointer did not advance");
  a_gain_read_word: assert property (gain_busy && gain_rdsel_ff && gain_tbl_ok
      |=> gain_rdata_ff == $past(gain_mem[gain_tsel_ff][gain_addr_ff]))
    else $error("debug read word wrong");
  a_def_clear_end: assert property (dstate_ff == lsd_pkg::DS_CLEAR && dm_clr_last
      |=> !dm_clr_ff && !dm_rd_ff && !dm_wr_ff && dm_idle)
    else $error("defect clear bit did not drop at end");
  sequence s_dm_xfer_done;
    (dstate_ff == lsd_pkg::DS_XFER) ##1 (dm_idle && !dm_wr_ff && !dm_rd_ff && !dm_arst_ff);
  endsequence
  a_def_xfer_clear: assert property (dm_go_xfer |=> s_dm_xfer_done)
    else $error("defect transfer bits not self-cleared");
  a_def_arst_zero: assert property (dm_go_xfer && wdata_in[lsd_pkg::DMC_ARST]
      |=> dm_addr_ff == '0)
    else $error("defect access not at offset zero");
  a_def_read_load: assert property (dm_load |=> ent_v_ff == $past(dm_q[lsd_pkg::ENTRY_W-1 -:
      lsd_pkg::EPOS_W]))
    else $error("defect read did not load data registers");
  a_shadow_latch: assert property (vs_rise
      |=> vline_corr_enable_out == $past(dctl_ff[lsd_pkg::DCTL_VEN])
      && general_defect_enable_out == $past(dctl_ff[lsd_pkg::DCTL_GEN]))
    else $error("enables not latched at vertical sync");
  a_shadow_hold: assert property (!vs_rise
      |=> $stable(vline_corr_enable_out) && $stable(general_defect_enable_out))
    else $error("enable changed outside vertical sync");
  a_shift_limit: assert property (vline_level_shift_out <= lsd_pkg::SHIFT_MAX)
    else $error("level shift above six");
endmodule

//--- lsd_regs_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; $display("[ERR] %0t got %h expected %h", $time, (g), (e)); end end
module lsd_regs_tb;
  logic clock_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [3:0] addr_in = 4'h0;
  logic [15:0] wdata_in = 16'h0000;
  logic write_in = 1'b0;
  logic read_in = 1'b0;
  logic vertical_sync_in = 1'b0;
  logic [15:0] rdata_out;
  logic vline_corr_enable_out;
  logic general_defect_enable_out;
  logic [2:0] vline_level_shift_out;
  logic vline_upper_disable_out;
  logic [1:0] vline_corr_mode_out;
  logic [13:0] vline_sat_level_out;
  logic [1:0] gain_factor_format_out;
  int errors = 0;
  int checks = 0;
  int seed = 32'h181a;
  logic [15:0] d, w, g0, g1;
  logic [15:0] h [3];
  logic [15:0] v [3];
  logic [15:0] kh [3];
  logic [15:0] kv [3];
  logic [15:0] e1 [5];
  logic [15:0] e2 [5];
  logic [15:0] ez [5];

  lsd_regs #(.GAIN_DEPTH(16), .DEFECT_DEPTH(4)) DUT (
    .clock_in(clock_in), .resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .write_in(write_in), .read_in(read_in), .vertical_sync_in(vertical_sync_in),
    .rdata_out(rdata_out), .vline_corr_enable_out(vline_corr_enable_out),
    .general_defect_enable_out(general_defect_enable_out),
    .vline_level_shift_out(vline_level_shift_out),
    .vline_upper_disable_out(vline_upper_disable_out),
    .vline_corr_mode_out(vline_corr_mode_out), .vline_sat_level_out(vline_sat_level_out),
    .gain_factor_format_out(gain_factor_format_out)
  );

  always #2 clock_in = ~clock_in;

  function automatic logic [2:0] exp_shift(input logic [2:0] s);
    return (s == 3'h7) ? 3'h6 : s;
  endfunction

  function automatic logic [15:0] ent_mask(input int i);
    return (i < 2) ? 16'h0FFF : 16'h00FF;
  endfunction

  task automatic finish_test();
    if (errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // strobe without the trailing idle cycle, so a read can follow at the next edge
  task automatic wr_nogap(input logic [3:0] a, input logic [15:0] dat);
    addr_in <= a;
    wdata_in <= dat;
    write_in <= 1'b1;
    @(posedge clock_in);
    write_in <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] dat);
    wr_nogap(a, dat);
    @(posedge clock_in);
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] q);
    addr_in <= a;
    read_in <= 1'b1;
    @(posedge clock_in);
    read_in <= 1'b0;
    #1 q = rdata_out;
    @(posedge clock_in);
  endtask

  // bounded poll until the self-clearing bits drop
  task automatic wait_clear(input logic [3:0] a, input logic [15:0] m);
    int n;
    n = 0;
    rd(a, d);
    while ((d & m) !== 16'h0000 && n < 40)
    begin
      rd(a, d);
      n++;
    end
    `CHK(d & m, 16'h0000)
  endtask

  task automatic gain_debug_read(input logic [15:0] ctl, input logic [15:0] exp);
    wr(4'h4, ctl);
    wr(4'h5, 16'($random(seed)));
    wait_clear(4'h4, 16'h0010);
    rd(4'h6, d);
    `CHK(d, exp)
  endtask

  task automatic load_entry(input logic [15:0] e [5]);
    for (int i = 0; i < 5; i++)
      wr(4'(11 + i), e[i]);
  endtask

  task automatic check_entry(input logic [15:0] e [5]);
    for (int i = 0; i < 5; i++)
    begin
      rd(4'(11 + i), d);
      `CHK(d, e[i] & ent_mask(i))
    end
  endtask

  initial
  begin
    #40000;
    errors++;
    finish_test();
  end

  initial
  begin
    repeat (12) @(posedge clock_in);
    resetn_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    for (int i = 0; i < 11; i++)
      if (i != 5 && i != 6)
      begin
        rd(4'(i), d);
        `CHK(d, 16'h0000)
      end
    `CHK(vline_corr_enable_out, 1'b0)
    for (int c = 0; c < 3; c++)
    begin
      h[c] = 16'($random(seed));
      v[c] = 16'($random(seed));
      kh[c] = 16'($random(seed));
      kv[c] = 16'($random(seed));
      wr(4'h0, {2'(c), h[c][13:0]});
      wr(4'h1, v[c]);
      wr(4'h2, kh[c]);
      wr(4'h3, kv[c]);
    end
    // reserved channel must neither store nor disturb the real ones
    wr(4'h0, 16'hC123);
    wr(4'h1, 16'h3FFF);
    rd(4'h1, d);
    `CHK(d, 16'h0000)
    for (int c = 2; c >= 0; c--)
    begin
      wr(4'h0, {2'(c), h[c][13:0]});
      rd(4'h0, d);
      `CHK(d, {2'(c), h[c][13:0]})
      rd(4'h1, d);
      `CHK(d, {2'b00, v[c][13:0]})
      rd(4'h2, d);
      `CHK(d, kh[c])
      rd(4'h3, d);
      `CHK(d, kv[c])
    end
    wr(4'hA, 16'hFFFF);
    rd(4'hA, d);
    `CHK(d, 16'h0030)
    `CHK(gain_factor_format_out, 2'h3)
    wr(4'hA, 16'h0000);
    g0 = 16'($random(seed));
    g1 = 16'($random(seed));
    wr(4'h4, 16'h0005);
    rd(4'h4, d);
    `CHK(d, 16'h0005)
    wr_nogap(4'h5, g0);
    rd(4'h4, d);
    `CHK(d, 16'h0011)
    wait_clear(4'h4, 16'h0010);
    wr(4'h5, g1);
    wait_clear(4'h4, 16'h0010);
    wr(4'h4, 16'h0007);
    wr(4'h5, 16'hFFFF);
    wait_clear(4'h4, 16'h0014);
    gain_debug_read(16'h000D, g0);
    gain_debug_read(16'h0009, g1);
    for (int k = 0; k < 8; k++)
    begin
      w = 16'($random(seed));
      w[10:8] = 3'(k);
      w[6:5] = 2'(k);
      wr(4'h7, w);
      rd(4'h7, d);
      `CHK(d, w & 16'h07F1)
      `CHK(vline_level_shift_out, exp_shift(3'(k)))
      `CHK(vline_upper_disable_out, w[7])
      `CHK(vline_corr_mode_out, w[6:5])
      w = 16'($random(seed));
      wr(4'h8, w);
      rd(4'h8, d);
      `CHK(d, w & 16'h3FFF)
      `CHK(vline_sat_level_out, w[13:0])
    end
    wr(4'h7, 16'h0011);
    `CHK({vline_corr_enable_out, general_defect_enable_out}, 2'b00)
    vertical_sync_in <= 1'b1;
    repeat (8) @(posedge clock_in);
    `CHK({vline_corr_enable_out, general_defect_enable_out}, 2'b11)
    // a held sync level must not resample mid-frame
    wr(4'h7, 16'h0000);
    vertical_sync_in <= 1'b0;
    repeat (8) @(posedge clock_in);
    `CHK({vline_corr_enable_out, general_defect_enable_out}, 2'b11)
    vertical_sync_in <= 1'b1;
    repeat (8) @(posedge clock_in);
    `CHK({vline_corr_enable_out, general_defect_enable_out}, 2'b00)
    for (int i = 0; i < 5; i++)
    begin
      e1[i] = 16'($random(seed));
      e2[i] = 16'($random(seed));
      ez[i] = 16'h0000;
    end
    load_entry(e1);
    wr(4'h9, 16'h0005);
    wait_clear(4'h9, 16'h0007);
    rd(4'h9, d);
    `CHK(d, 16'h0000)
    load_entry(e2);
    wr(4'h9, 16'h0001);
    wait_clear(4'h9, 16'h0007);
    load_entry(ez);
    wr(4'h9, 16'h0006);
    wait_clear(4'h9, 16'h0007);
    check_entry(e1);
    wr(4'h9, 16'h0002);
    wait_clear(4'h9, 16'h0007);
    check_entry(e2);
    wr(4'h9, 16'h0010);
    rd(4'h9, d);
    `CHK(d[4], 1'b1)
    wait_clear(4'h9, 16'h0010);
    wr(4'h9, 16'h0006);
    wait_clear(4'h9, 16'h0007);
    check_entry(ez);
    // clear written together with a read: every self-clearing bit must drop
    wr(4'h9, 16'h0012);
    wait_clear(4'h9, 16'h0017);
    finish_test();
  end
endmodule
